// >>> core/pgb_port_bank.sv
// port bank top: axi4-lite registers, pin logic and checks
//
// Local design decisions: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/100ps
// Notes on behaviour
// - each pin is input or output on its own, chosen by its bit in the port direction register.
// - the data register holds the values driven out and reads back the latch for output pins and the sampled pin levels for input pins.
// - direction, pull-up, analog disable and threshold select registers read back what was written.
// - a plain data read may differ from the written value; a latch view read returns the latch of the built pins.
// - port 0 is built with eight, three or seven pins by variant, each an independent two-way lane.
// - port 0 has a per-pin pull-up enable register.
// - port 0 has a per-pin analog disable register choosing analog use or digital input.
// - port 0 has a threshold select choosing hysteresis or cmos input on the one pin that has both.
// - each port 0 pin serves as plain i/o or carries a shared peripheral signal.
// - a direction bit of one drives the latch onto the pin; zero makes the pin an input.
// - for an input pin a data write updates only the latch and a plain read returns the pin.
// - the float bit in stop or watch mode floats the pins and holds inputs low, except interrupt-enabled pins.
// - an enabled pull-up is cut off while its pin drives low.
module pgb_port_bank
  import pgb_pkg::*;
#(
  parameter int AW = 8,
  parameter logic [7:0] P0_PIN_MASK = 8'hFF,
  parameter logic [7:0] P0_ANALOG_MASK = 8'h3F
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [AW-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [AW-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [NPORT-1:0][PW-1:0] pin_in,
  output logic [NPORT-1:0][PW-1:0] pin_out,
  output logic [NPORT-1:0][PW-1:0] pin_oe_n,
  output logic [NPORT-1:0][PW-1:0] pull_en,
  input wire logic [NPORT-1:0][PW-1:0] periph_oe,
  input wire logic [NPORT-1:0][PW-1:0] periph_out,
  output logic [NPORT-1:0][PW-1:0] periph_in,
  input wire logic [PW-1:0] ext_int_en,
  input wire logic stop_watch_mode,
  output logic [PW-1:0] analog_en,
  output logic p04_cmos_sel
);

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  function automatic logic [4:0] reg_id(input logic [AW-1:0] addr);
    logic [7:0] a;
    logic [4:0] id;
    a = {addr[7:2], 2'b00};
    id = RID_NONE;
    for (int p = 0; p < NPORT; p++) begin
      if (a == ADR_DATA_BASE + 8'(p) * ADR_PORT_STRIDE) begin
        id = RID_DATA0 + 5'(p);
      end
      if (a == ADR_DIR_BASE + 8'(p) * ADR_PORT_STRIDE) begin
        id = RID_DIR0 + 5'(p);
      end
      if (a == ADR_LATCH_VIEW_BASE + 8'(p) * ADR_LATCH_VIEW_STRIDE) begin
        id = RID_LATCH_VIEW0 + 5'(p);
      end
    end
    if (a == ADR_PORT0_PULLUP) begin
      id = RID_PORT0_PULLUP;
    end
    if (a == ADR_PORTG_PULLUP) begin
      id = RID_PORTG_PULLUP;
    end
    if (a == ADR_ANALOG_DIS) begin
      id = RID_ANALOG_DIS;
    end
    if (a == ADR_THRESH_SEL) begin
      id = RID_THRESH_SEL;
    end
    if (a == ADR_STANDBY_CTRL) begin
      id = RID_STANDBY_CTRL;
    end
    return id;
  endfunction

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [NPORT-1:0][PW-1:0] data_q;
  logic [NPORT-1:0][PW-1:0] data_d;
  logic [NPORT-1:0][PW-1:0] dir_q;
  logic [NPORT-1:0][PW-1:0] dir_d;
  logic [PW-1:0] pullup0_q;
  logic [PW-1:0] pullup0_d;
  logic [PW-1:0] pullupg_q;
  logic [PW-1:0] pullupg_d;
  logic [PW-1:0] analog_dis_q;
  logic [PW-1:0] analog_dis_d;
  logic [PW-1:0] thresh_sel_q;
  logic [PW-1:0] thresh_sel_d;
  logic [PW-1:0] standby_q;
  logic [PW-1:0] standby_d;
  logic aw_hold_q;
  logic aw_hold_d;
  logic [AW-1:0] awaddr_q;
  logic [AW-1:0] awaddr_d;
  logic w_hold_q;
  logic w_hold_d;
  logic [31:0] wdata_q;
  logic [31:0] wdata_d;
  logic wstrb0_q;
  logic wstrb0_d;
  logic bvalid_q;
  logic bvalid_d;
  logic [1:0] bresp_q;
  logic [1:0] bresp_d;
  logic rvalid_q;
  logic rvalid_d;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic [1:0] rresp_q;
  logic [1:0] rresp_d;

  logic wr_fire;
  logic ar_fire;
  logic [4:0] wid;
  logic [4:0] rid;
  logic float_en;
  logic [NPORT-1:0][PW-1:0] pin_sync;
  logic [NPORT-1:0][PW-1:0] rd_w;
  logic [NPORT-1:0][PW-1:0] mask_w;
  logic [NPORT-1:0][PW-1:0] pull_w;
  logic [NPORT-1:0][PW-1:0] dig_w;
  logic [NPORT-1:0][PW-1:0] exempt_w;

  // ----------------------------------------------------------------
  // axi4-lite handshakes
  // ----------------------------------------------------------------
  assign s_axi_awready = !aw_hold_q && !bvalid_q;
  assign s_axi_wready = !w_hold_q && !bvalid_q;
  assign s_axi_arready = !rvalid_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;
  assign wr_fire = aw_hold_q && w_hold_q;
  assign ar_fire = s_axi_arvalid && !rvalid_q;
  assign wid = reg_id(awaddr_q);
  assign rid = reg_id(s_axi_araddr);

  always_comb begin
    aw_hold_d = aw_hold_q;
    awaddr_d = awaddr_q;
    w_hold_d = w_hold_q;
    wdata_d = wdata_q;
    wstrb0_d = wstrb0_q;
    bvalid_d = bvalid_q;
    bresp_d = bresp_q;
    if (s_axi_awvalid && s_axi_awready) begin
      aw_hold_d = 1'b1;
      awaddr_d = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      w_hold_d = 1'b1;
      wdata_d = s_axi_wdata;
      wstrb0_d = s_axi_wstrb[0];
    end
    if (wr_fire) begin
      aw_hold_d = 1'b0;
      w_hold_d = 1'b0;
      bvalid_d = 1'b1;
      bresp_d = (wid < RID_LATCH_VIEW0) ? RESP_OKAY : RESP_SLVERR;
    end else if (bvalid_q && s_axi_bready) begin
      bvalid_d = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // register writes
  // ----------------------------------------------------------------
  always_comb begin
    data_d = data_q;
    dir_d = dir_q;
    pullup0_d = pullup0_q;
    pullupg_d = pullupg_q;
    analog_dis_d = analog_dis_q;
    thresh_sel_d = thresh_sel_q;
    standby_d = standby_q;
    if (wr_fire && wstrb0_q) begin
      for (int p = 0; p < NPORT; p++) begin
        if (wid == RID_DATA0 + 5'(p)) begin
          data_d[p] = wdata_q[PW-1:0];
        end
        if (wid == RID_DIR0 + 5'(p)) begin
          dir_d[p] = wdata_q[PW-1:0];
        end
      end
      if (wid == RID_PORT0_PULLUP) begin
        pullup0_d = wdata_q[PW-1:0];
      end
      if (wid == RID_PORTG_PULLUP) begin
        pullupg_d = wdata_q[PW-1:0];
      end
      if (wid == RID_ANALOG_DIS) begin
        analog_dis_d = wdata_q[PW-1:0];
      end
      if (wid == RID_THRESH_SEL) begin
        thresh_sel_d = wdata_q[PW-1:0];
      end
      if (wid == RID_STANDBY_CTRL) begin
        standby_d = wdata_q[PW-1:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // register reads
  // ----------------------------------------------------------------
  always_comb begin
    rvalid_d = rvalid_q;
    rdata_d = rdata_q;
    rresp_d = rresp_q;
    if (ar_fire) begin
      rvalid_d = 1'b1;
      rdata_d = 32'h0000_0000;
      rresp_d = RESP_OKAY;
      for (int p = 0; p < NPORT; p++) begin
        if (rid == RID_DATA0 + 5'(p)) begin
          rdata_d[PW-1:0] = rd_w[p];
        end
        if (rid == RID_DIR0 + 5'(p)) begin
          rdata_d[PW-1:0] = dir_q[p];
        end
        if (rid == RID_LATCH_VIEW0 + 5'(p)) begin
          rdata_d[PW-1:0] = data_q[p] & mask_w[p];
        end
      end
      if (rid == RID_PORT0_PULLUP) begin
        rdata_d[PW-1:0] = pullup0_q;
      end
      if (rid == RID_PORTG_PULLUP) begin
        rdata_d[PW-1:0] = pullupg_q;
      end
      if (rid == RID_ANALOG_DIS) begin
        rdata_d[PW-1:0] = analog_dis_q;
      end
      if (rid == RID_THRESH_SEL) begin
        rdata_d[PW-1:0] = thresh_sel_q;
      end
      if (rid == RID_STANDBY_CTRL) begin
        rdata_d[PW-1:0] = standby_q;
      end
      if (rid == RID_NONE) begin
        rresp_d = RESP_SLVERR;
      end
    end else if (rvalid_q && s_axi_rready) begin
      rvalid_d = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      data_q <= '0;
      dir_q <= '0;
      pullup0_q <= RST_REG;
      pullupg_q <= RST_REG;
      analog_dis_q <= RST_REG;
      thresh_sel_q <= RST_REG;
      standby_q <= RST_REG;
      aw_hold_q <= 1'b0;
      awaddr_q <= '0;
      w_hold_q <= 1'b0;
      wdata_q <= 32'h0000_0000;
      wstrb0_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= RESP_OKAY;
    end else begin
      data_q <= data_d;
      dir_q <= dir_d;
      pullup0_q <= pullup0_d;
      pullupg_q <= pullupg_d;
      analog_dis_q <= analog_dis_d;
      thresh_sel_q <= thresh_sel_d;
      standby_q <= standby_d;
      aw_hold_q <= aw_hold_d;
      awaddr_q <= awaddr_d;
      w_hold_q <= w_hold_d;
      wdata_q <= wdata_d;
      wstrb0_q <= wstrb0_d;
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
      rvalid_q <= rvalid_d;
      rdata_q <= rdata_d;
      rresp_q <= rresp_d;
    end
  end

  // ----------------------------------------------------------------
  // pins
  // ----------------------------------------------------------------
  assign float_en = standby_q[FLOAT_BIT] && stop_watch_mode;
  assign analog_en = P0_ANALOG_MASK & P0_PIN_MASK & ~analog_dis_q;
  assign p04_cmos_sel = thresh_sel_q[P04_SEL_BIT];

  pgb_sync #(
    .W(NPORT * PW)
  ) u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .async_in(pin_in),
    .sync_out(pin_sync)
  );

  for (genvar p = 0; p < NPORT; p++) begin : g_lane
    assign mask_w[p] = (p == PORT0) ? P0_PIN_MASK : {PW{1'b1}};
    assign pull_w[p] = (p == PORT0) ? pullup0_q : ((p == PORTG) ? pullupg_q : RST_REG);
    assign dig_w[p] = (p == PORT0) ? (~P0_ANALOG_MASK | analog_dis_q) : {PW{1'b1}};
    assign exempt_w[p] = (p == PORT0) ? ext_int_en : RST_REG;
    pgb_lane #(
      .W(PW)
    ) u_lane (
      .pin_mask(mask_w[p]),
      .latch(data_q[p]),
      .dir(dir_q[p]),
      .periph_oe(periph_oe[p]),
      .periph_out(periph_out[p]),
      .pull_req(pull_w[p]),
      .dig_en(dig_w[p]),
      .exempt(exempt_w[p]),
      .float_en(float_en),
      .pin_sync(pin_sync[p]),
      .pin_out(pin_out[p]),
      .pin_oe_n(pin_oe_n[p]),
      .pull_en(pull_en[p]),
      .din(periph_in[p]),
      .rd(rd_w[p])
    );
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_dir_sets_drive: assert property (!float_en |-> pin_oe_n[PORT1] == ~(dir_q[PORT1] | periph_oe[PORT1]))
    else $error("direction does not steer drive");
  a_latch_view_read: assert property (ar_fire && rid == RID_LATCH_VIEW0 |=> rdata_q[PW-1:0] == $past(data_q[PORT0] & mask_w[PORT0]))
    else $error("latch view read wrong");
  a_plain_data_read: assert property (ar_fire && rid == RID_DATA0 + 5'd1 |=> rdata_q[PW-1:0] == $past(rd_w[PORT1]))
    else $error("data read wrong");
  a_dir_write_echo: assert property (wr_fire && wstrb0_q && wid == RID_DIR0 + 5'd2 |=> dir_q[PORT6] == $past(wdata_q[PW-1:0]))
    else $error("direction write not taken");
  a_pullup_cut_low: assert property ((pull_en[PORT0] & ~pin_oe_n[PORT0] & ~pin_out[PORT0]) == RST_REG)
    else $error("pull-up on low drive");
  a_float_no_drive: assert property (float_en |-> pin_oe_n == '1 && (periph_in[PORT0] & ~ext_int_en) == RST_REG)
    else $error("float mode not applied");
  a_unbuilt_pins: assert property ((pin_oe_n[PORT0] | P0_PIN_MASK) == {PW{1'b1}} && (rd_w[PORT0] & ~P0_PIN_MASK) == RST_REG)
    else $error("unbuilt pin active");
  a_sync_two_cycles: assert property (!float_en |-> periph_in[PORTF] == $past(pin_in[PORTF], 2))
    else $error("input sync delay wrong");
  a_analog_gates_in: assert property ((periph_in[PORT0] & P0_ANALOG_MASK & ~analog_dis_q) == RST_REG)
    else $error("analog pin reads digital");
  a_write_response: assert property (wr_fire |=> s_axi_bvalid && !s_axi_awready && !s_axi_wready)
    else $error("write response missing");

endmodule // pgb_port_bank

// >>> shared/pgb_pkg.sv
// shared constants for the general-purpose port bank
package pgb_pkg;

  // ----------------------------------------------------------------
  // sizes
  // ----------------------------------------------------------------
  localparam int NPORT = 5;
  localparam int PW = 8;
  localparam int SYNC_STAGES = 2;

  // ----------------------------------------------------------------
  // port indices
  // ----------------------------------------------------------------
  localparam int PORT0 = 0;
  localparam int PORT1 = 1;
  localparam int PORT6 = 2;
  localparam int PORTF = 3;
  localparam int PORTG = 4;

  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] ADR_DATA_BASE = 8'h00;
  localparam logic [7:0] ADR_DIR_BASE = 8'h04;
  localparam logic [7:0] ADR_PORT_STRIDE = 8'h08;
  localparam logic [7:0] ADR_PORT0_PULLUP = 8'h28;
  localparam logic [7:0] ADR_PORTG_PULLUP = 8'h2C;
  localparam logic [7:0] ADR_ANALOG_DIS = 8'h30;
  localparam logic [7:0] ADR_THRESH_SEL = 8'h34;
  localparam logic [7:0] ADR_STANDBY_CTRL = 8'h38;
  localparam logic [7:0] ADR_LATCH_VIEW_BASE = 8'h40;
  localparam logic [7:0] ADR_LATCH_VIEW_STRIDE = 8'h04;

  // ----------------------------------------------------------------
  // register ids from the address decoder
  // ----------------------------------------------------------------
  localparam logic [4:0] RID_DATA0 = 5'h00;
  localparam logic [4:0] RID_DIR0 = 5'h05;
  localparam logic [4:0] RID_PORT0_PULLUP = 5'h0A;
  localparam logic [4:0] RID_PORTG_PULLUP = 5'h0B;
  localparam logic [4:0] RID_ANALOG_DIS = 5'h0C;
  localparam logic [4:0] RID_THRESH_SEL = 5'h0D;
  localparam logic [4:0] RID_STANDBY_CTRL = 5'h0E;
  localparam logic [4:0] RID_LATCH_VIEW0 = 5'h0F;
  localparam logic [4:0] RID_NONE = 5'h1F;

  // ----------------------------------------------------------------
  // fields and reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_REG = 8'h00;
  localparam int FLOAT_BIT = 0;
  localparam int P04_SEL_BIT = 2;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

endpackage

// >>> core/pgb_sync.sv
// two-stage synchroniser for the pin inputs
`timescale 1ns/100ps
module pgb_sync
  import pgb_pkg::*;
#(
  parameter int W = 8
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);

  logic [W-1:0] meta_q;
  logic [W-1:0] meta_d;
  logic [W-1:0] sync_q;
  logic [W-1:0] sync_d;

  always_comb begin
    meta_d = async_in;
    sync_d = meta_q;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign sync_out = sync_q;

endmodule // pgb_sync

// >>> core/pgb_lane.sv
// pin drive, pull-up and input gating for one port
`timescale 1ns/100ps
module pgb_lane
  import pgb_pkg::*;
#(
  parameter int W = 8
) (
  input wire logic [W-1:0] pin_mask,
  input wire logic [W-1:0] latch,
  input wire logic [W-1:0] dir,
  input wire logic [W-1:0] periph_oe,
  input wire logic [W-1:0] periph_out,
  input wire logic [W-1:0] pull_req,
  input wire logic [W-1:0] dig_en,
  input wire logic [W-1:0] exempt,
  input wire logic float_en,
  input wire logic [W-1:0] pin_sync,
  output logic [W-1:0] pin_out,
  output logic [W-1:0] pin_oe_n,
  output logic [W-1:0] pull_en,
  output logic [W-1:0] din,
  output logic [W-1:0] rd
);

  logic [W-1:0] drive;
  logic [W-1:0] cut;
  logic [W-1:0] use_latch;

  always_comb begin
    cut = {W{float_en}} & ~exempt;
    drive = {W{~float_en}} & (dir | periph_oe) & pin_mask;
    pin_out = ((periph_oe & periph_out) | (~periph_oe & latch)) & pin_mask;
    pin_oe_n = ~drive;
    pull_en = pull_req & pin_mask & ~(drive & ~pin_out);
    din = pin_sync & pin_mask & dig_en & ~cut;
    use_latch = dir & ~periph_oe;
    rd = ((use_latch & latch) | (~use_latch & din)) & pin_mask;
  end

endmodule // pgb_lane

// >>> verif/pgb_pin_model.sv
// board-side model of the pins facing the port bank
`timescale 1ns/100ps
module pgb_pin_model
  import pgb_pkg::*;
(
  input wire logic aclk,
  input wire logic [NPORT-1:0][PW-1:0] pin_out,
  input wire logic [NPORT-1:0][PW-1:0] pin_oe_n,
  input wire logic [NPORT-1:0][PW-1:0] pull_en,
  input wire logic [NPORT-1:0][PW-1:0] ext_en,
  input wire logic [NPORT-1:0][PW-1:0] ext_val,
  output logic [NPORT-1:0][PW-1:0] pin_in
);
  // ----------------------------------------------------------------
  // wire level
  // ----------------------------------------------------------------
  // open, unpulled pins wander every cycle
  logic [NPORT-1:0][PW-1:0] wander_q = '0;

  always @(posedge aclk) begin
    wander_q <= ~wander_q;
  end

  // bank drive wins over the weak board source, then pull-up
  assign pin_in = (~pin_oe_n & pin_out) | (pin_oe_n & ext_en & ext_val) |
                  (pin_oe_n & ~ext_en & (pull_en | wander_q));
endmodule // pgb_pin_model

// >>> verif/pgb_port_bank_bench.sv
// self-checking bench for the port bank
`timescale 1ns/100ps
module pgb_port_bank_bench
  import pgb_pkg::*;
;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] aw_a, ar_a;
  logic [31:0] w_d, r_d;
  logic [3:0] w_s;
  logic aw_v, w_v, b_r, ar_v, r_r, aw_r, w_r, b_v, ar_r, r_v;
  logic [1:0] b_resp, r_resp;
  logic [NPORT-1:0][PW-1:0] pin_in, pin_out, pin_oe_n, pull_en, periph_oe, periph_out, periph_in, ext_en, ext_val;
  logic [PW-1:0] ext_int_en, analog_en;
  logic swm, p04_cmos_sel;
  int n_errors = 0;
  int n_checks = 0;
  logic [7:0] cfg_a [4] = '{ADR_PORT0_PULLUP, ADR_PORTG_PULLUP, ADR_ANALOG_DIS, ADR_THRESH_SEL};
  logic [7:0] cfg_v [4] = '{8'hFF, 8'hFF, 8'hFF, 8'h04};

  always #10 aclk = ~aclk;

  pgb_port_bank i_pgb_port_bank (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(aw_a), .s_axi_awprot(3'b000), .s_axi_awvalid(aw_v), .s_axi_awready(aw_r),
    .s_axi_wdata(w_d), .s_axi_wstrb(w_s), .s_axi_wvalid(w_v), .s_axi_wready(w_r),
    .s_axi_bresp(b_resp), .s_axi_bvalid(b_v), .s_axi_bready(b_r),
    .s_axi_araddr(ar_a), .s_axi_arprot(3'b000), .s_axi_arvalid(ar_v), .s_axi_arready(ar_r),
    .s_axi_rdata(r_d), .s_axi_rresp(r_resp), .s_axi_rvalid(r_v), .s_axi_rready(r_r),
    .pin_in(pin_in), .pin_out(pin_out), .pin_oe_n(pin_oe_n), .pull_en(pull_en),
    .periph_oe(periph_oe), .periph_out(periph_out), .periph_in(periph_in),
    .ext_int_en(ext_int_en), .stop_watch_mode(swm), .analog_en(analog_en), .p04_cmos_sel(p04_cmos_sel)
  );

  pgb_pin_model i_pgb_pin_model (
    .aclk(aclk), .pin_out(pin_out), .pin_oe_n(pin_oe_n), .pull_en(pull_en),
    .ext_en(ext_en), .ext_val(ext_val), .pin_in(pin_in)
  );

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [7:0] da(input int p);
    return 8'(ADR_DATA_BASE + ADR_PORT_STRIDE * p);
  endfunction

  function automatic logic [7:0] dr(input int p);
    return 8'(ADR_DIR_BASE + ADR_PORT_STRIDE * p);
  endfunction

  function automatic logic [7:0] lv(input int p);
    return 8'(ADR_LATCH_VIEW_BASE + ADR_LATCH_VIEW_STRIDE * p);
  endfunction

  task automatic finish_test();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected response at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic mid();
    repeat (2) @(posedge aclk);
    @(negedge aclk);
  endtask

  // ----------------------------------------------------------------
  // axi4-lite master
  // ----------------------------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [3:0] s, input logic [1:0] er);
    logic pa, pw, hit;
    logic [1:0] resp;
    int i;
    @(posedge aclk);
    aw_a <= a;
    w_d <= 32'(d);
    w_s <= s;
    aw_v <= 1'b1;
    w_v <= 1'b1;
    pa = 1'b1;
    pw = 1'b1;
    hit = 1'b0;
    for (i = 0; i < 50 && (pa || pw); i++) begin
      @(negedge aclk);
      pa = pa && !aw_r;
      pw = pw && !w_r;
      @(posedge aclk);
      aw_v <= pa;
      w_v <= pw;
    end
    b_r <= 1'b1;
    for (i = 0; i < 50 && !hit; i++) begin
      @(negedge aclk);
      hit = b_v;
      resp = b_resp;
      @(posedge aclk);
    end
    b_r <= 1'b0;
    if (!hit || pa || pw) begin
      n_errors++;
      finish_test();
    end
    chk_resp(resp, er);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    logic hit;
    logic [31:0] d;
    logic [1:0] resp;
    int i;
    @(posedge aclk);
    ar_a <= a;
    ar_v <= 1'b1;
    hit = 1'b0;
    for (i = 0; i < 50 && !hit; i++) begin
      @(negedge aclk);
      hit = ar_r;
      @(posedge aclk);
    end
    ar_v <= 1'b0;
    r_r <= 1'b1;
    hit = 1'b0;
    for (i = 0; i < 50 && !hit; i++) begin
      @(negedge aclk);
      hit = r_v;
      d = r_d;
      resp = r_resp;
      @(posedge aclk);
    end
    r_r <= 1'b0;
    if (!hit) begin
      n_errors++;
      finish_test();
    end
    chk(d, ed);
    chk_resp(resp, er);
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  initial begin
    aw_a = '0; ar_a = '0; w_d = '0; w_s = '0;
    aw_v = 1'b0; w_v = 1'b0; b_r = 1'b0; ar_v = 1'b0; r_r = 1'b0;
    periph_oe = '0; periph_out = '0; ext_en = '1; ext_val = '0;
    ext_int_en = '0; swm = 1'b0;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    mid();
    chk(pin_oe_n, {NPORT{8'hFF}});
    chk(pull_en, '0);
    chk(analog_en, 8'h3F);
    for (int p = 0; p < NPORT; p++) begin
      rd(da(p), 0, RESP_OKAY);
      rd(dr(p), 0, RESP_OKAY);
    end
    for (int k = 0; k < 4; k++) begin
      rd(cfg_a[k], 0, RESP_OKAY);
      wr(cfg_a[k], cfg_v[k], 4'hF, RESP_OKAY);
      rd(cfg_a[k], 32'(cfg_v[k]), RESP_OKAY);
    end
    mid();
    chk(p04_cmos_sel, 1'b1);
    chk(analog_en, 8'h00);
    // per-port direction and data
    @(posedge aclk);
    ext_val <= {NPORT{8'hA5}};
    for (int p = 0; p < NPORT; p++) begin
      wr(da(p), 8'h3C, 4'hF, RESP_OKAY);
      wr(dr(p), 8'h0F, 4'hF, RESP_OKAY);
      mid();
      chk(pin_oe_n[p], 8'hF0);
      chk(pin_out[p] & 8'h0F, 8'h0C);
      rd(da(p), 32'h0000_00AC, RESP_OKAY);
      rd(lv(p), 32'h0000_003C, RESP_OKAY);
      rd(dr(p), 32'h0000_000F, RESP_OKAY);
    end
    chk(pull_en, {8'hFC, 24'h00_0000, 8'hFC});
    @(posedge aclk);
    ext_en[0] <= 8'h00;
    mid();
    rd(da(0), 32'h0000_00FC, RESP_OKAY);
    // shared peripheral takes port 1 upper pins
    @(posedge aclk);
    periph_oe[1] <= 8'hF0;
    periph_out[1] <= 8'h50;
    mid();
    chk(pin_out[1], 8'h5C);
    chk(pin_oe_n[1], 8'h00);
    chk(periph_in[3], 8'hAC);
    rd(da(1), 32'h0000_005C, RESP_OKAY);
    // input synchroniser depth
    @(posedge aclk);
    ext_val[3] <= 8'h5A;
    @(posedge aclk);
    @(negedge aclk);
    chk(periph_in[3], 8'hAC);
    @(negedge aclk);
    chk(periph_in[3], 8'h5C);
    // float in stop or watch mode
    wr(ADR_STANDBY_CTRL, 8'h01, 4'hF, RESP_OKAY);
    @(posedge aclk);
    ext_int_en <= 8'h04;
    swm <= 1'b1;
    mid();
    chk(pin_oe_n, {NPORT{8'hFF}});
    chk(periph_in, 40'h00_0000_0004);
    @(posedge aclk);
    swm <= 1'b0;
    mid();
    chk(pin_oe_n[0], 8'hF0);
    // refused and ignored accesses
    wr(8'h3C, 8'hFF, 4'hF, RESP_SLVERR);
    rd(8'h3C, 0, RESP_SLVERR);
    wr(lv(0), 8'h00, 4'hF, RESP_SLVERR);
    rd(lv(0), 32'h0000_003C, RESP_OKAY);
    wr(dr(0), 8'h00, 4'h0, RESP_OKAY);
    rd(dr(0), 32'h0000_000F, RESP_OKAY);
    rd(ADR_STANDBY_CTRL, 32'h0000_0001, RESP_OKAY);
    finish_test();
  end
endmodule // pgb_port_bank_bench
